// ### hw/ict_carrier_gen.sv
`timescale 1ns/1ps
module ict_carrier_gen #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         run,
  input  wire logic [1:0]   sel,
  input  wire logic [W-1:0] high_period,
  input  wire logic [W-1:0] low_period,
  output logic              level,
  output logic              fall
);
  import ict_pkg::*;

  initial begin
    if (W < 1 || W > 16) $error("ict_carrier_gen: W out of range");
  end

  ict_phase_t   ph_reg, ph_next;
  logic [W+3:0] acc_reg, acc_next;
  logic         fall_reg, fall_next;
  logic [W+3:0] target;
  logic [W+3:0] stepped;
  logic [W+3:0] span;

  // Phase length in 2x-clock units: (value + 1) scaled by selection
  always_comb begin
    span = ph_reg == PH_HIGH ? {4'h0, high_period} : {4'h0, low_period};
    span = span + (W+4)'(1);
    case (sel)
      CCK_FULL:   target = span << SH_FULL;
      CCK_DOUBLE: target = span << SH_DOUBLE;
      default:    target = span << SH_HALF;
    endcase
    stepped = acc_reg + (W+4)'(UNITS_PER_CLK);
  end

  // Phase sequencer; stopped generator waits at start of low phase
  always_comb begin
    acc_next  = acc_reg;
    ph_next   = ph_reg;
    fall_next = 1'b0;
    if (!run) begin
      acc_next = '0;
      ph_next  = PH_LOW;
    end else if (stepped >= target) begin
      acc_next  = stepped - target;
      ph_next   = ph_reg == PH_HIGH ? PH_LOW : PH_HIGH;
      fall_next = ph_reg == PH_HIGH;
    end else begin
      acc_next = stepped;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_reg  <= '0;
      ph_reg   <= PH_LOW;
      fall_reg <= 1'b0;
    end else begin
      acc_reg  <= acc_next;
      ph_reg   <= ph_next;
      fall_reg <= fall_next;
    end
  end

  assign level = ph_reg == PH_HIGH;
  assign fall  = fall_reg;

endmodule // ict_carrier_gen

// ### hw/ict_mod_timer.sv
`timescale 1ns/1ps
module ict_mod_timer #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         tick,
  input  wire logic         en,
  input  wire logic         clr,
  input  wire logic [W-1:0] modulo,
  output logic [W-1:0]      count,
  output logic              match
);

  initial begin
    if (W < 2 || W > 16) $error("ict_mod_timer: W out of range");
  end

  logic [W-1:0] cnt_reg, cnt_next;
  logic         hit_reg, hit_next;
  logic         match_reg, match_next;
  logic [W-1:0] nv;

  // Counter with restart after the matching value
  always_comb begin
    cnt_next   = cnt_reg;
    hit_next   = hit_reg;
    match_next = 1'b0;
    nv         = hit_reg ? '0 : cnt_reg + W'(1);
    if (clr) begin
      cnt_next = '0;
      hit_next = 1'b0;
    end else if (en && tick) begin
      cnt_next   = nv;
      hit_next   = (nv == modulo) && (modulo != '0);
      match_next = hit_next;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg   <= '0;
      hit_reg   <= 1'b0;
      match_reg <= 1'b0;
    end else begin
      cnt_reg   <= cnt_next;
      hit_reg   <= hit_next;
      match_reg <= match_next;
    end
  end

  assign count = cnt_reg;
  assign match = match_reg;

endmodule // ict_mod_timer

// ### hw/ict_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Counter reaching a nonzero modulo sets the match flag at 3FH bit 0.
// - Clock select 00/01/10 picks system clock /32, /64, /256; 11 the carrier.
// - Count enable at 33H bit 3 stops or allows counting on falling edges.
// - Writing 1 to 33H bit 2 clears the counter, and the flag unless a match sets it that cycle; reads as 0.
// - Counter is read-only; modulo is write-only through the transfer buffer.
// - Carrier clock select at 13H: half, equal or double the system clock.
// - Carrier uses own counter with high and low period registers.
// - Each carrier phase lasts loaded value plus one carrier clocks.
// - Both carrier period registers are readable and writable.
// - Carrier disable at 12H bit 1 forces the pin high.
// - Live gate 1 drives the carrier onto the pin, gate 0 drives low.
// - Each match copies the buffered gate at 11H into the live gate.
// - A match during a high carrier pulse keeps the pin until it falls.
// - Carrier stops with gate 0 once any held pulse has fallen, unless it clocks the timer.
// - Buffered gate set starts with one low phase before the high pulse.
module ict_top #(
  parameter int TW = 8,
  parameter int CW = 8
) (
  input  wire logic                  I_CORE_CLK,
  input  wire logic                  I_SYS_RST,
  input  wire ict_pkg::ict_rf_req_t  I_RF_REQ,
  input  wire ict_pkg::ict_per_req_t I_PER_REQ,
  output logic [3:0]                 O_RF_RDATA,
  output logic [15:0]                O_PER_RDATA,
  output logic                       O_MATCH_IRQ_FLAG,
  output logic                       O_CARRIER_OUT_PIN
);
  import ict_pkg::*;

  // Elaboration checks on widths and on the package layout
  initial begin
    if (TW != 8) begin
      $error("ict_top: timer width must be 8");
    end
    if (CW != 8) begin
      $error("ict_top: carrier width must be 8");
    end
    if (B_CNT_EN > 3 || B_CNT_CLR > 3 || B_CAR_DIS > 3) begin
      $error("ict_top: control bit outside its 4-bit word");
    end
    if (B_CNT_EN < 2 || B_CNT_CLR < 2) begin
      $error("ict_top: control bits overlap the clock select");
    end
    if (B_GATE == B_CAR_DIS) begin
      $error("ict_top: gate and disable bits share a position");
    end
    if (PR_TIMER == PR_CARRIER) begin
      $error("ict_top: peripheral addresses collide");
    end
    if (RF_GATE_BUF == RF_GATE || RF_CAR_SEL == RF_TMR_CTL || RF_IRQ == RF_TMR_CTL) begin
      $error("ict_top: register-file locations collide");
    end
    if (DIV32_MASK > DIV64_MASK || DIV64_MASK > DIV256_MASK) begin
      $error("ict_top: divider masks out of order");
    end
    if (TMR_CTL_RST[B_CNT_CLR] != 1'b0) begin
      $error("ict_top: clear bit must reset to zero");
    end
  end

  // Register-file state
  logic          gate_buf_reg, gate_buf_next;
  logic          gate_reg, gate_next;
  logic          car_dis_reg, car_dis_next;
  logic [1:0]    car_sel_reg, car_sel_next;
  logic          cnt_en_reg, cnt_en_next;
  logic [1:0]    cnt_sel_reg, cnt_sel_next;
  logic          flag_reg, flag_next;
  // Peripheral registers
  logic [TW-1:0] modulo_reg, modulo_next;
  logic [CW-1:0] high_reg, high_next;
  logic [CW-1:0] low_reg, low_next;
  // Prescaler, pin and read paths
  logic [7:0]    div_reg, div_next;
  logic          hold_reg, hold_next;
  logic          pin_reg, pin_next;
  logic [3:0]    rf_rd_reg, rf_rd_next;
  logic [15:0]   per_rd_reg, per_rd_next;

  logic          rf_wr;
  logic          ctl_wr;
  logic          cnt_clr;
  logic          tick;
  logic [7:0]    div_mask;
  logic          car_level;
  logic          car_fall;
  logic          car_run;
  logic [TW-1:0] count;
  logic          match;

  // Write decode for the timer control location
  assign rf_wr   = I_RF_REQ.we;
  assign ctl_wr  = rf_wr && I_RF_REQ.addr == RF_TMR_CTL;
  assign cnt_clr = ctl_wr && I_RF_REQ.wdata[B_CNT_CLR];

  // Free-running system clock divider
  always_comb begin
    div_next = div_reg + 8'h01;
  end

  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_next;
    end
  end

  // Count clock selection; tick marks the selected falling edge
  always_comb begin
    case (cnt_sel_reg)
      TCK_DIV32:  div_mask = DIV32_MASK;
      TCK_DIV64:  div_mask = DIV64_MASK;
      TCK_DIV256: div_mask = DIV256_MASK;
      default:    div_mask = DIV256_MASK;
    endcase
    if (cnt_sel_reg == TCK_CARR) begin
      tick = car_fall;
    end else begin
      tick = (div_reg & div_mask) == div_mask;
    end
  end

  ict_mod_timer #(
    .W (TW)
  ) u_timer (
    .clk    (I_CORE_CLK),
    .rst    (I_SYS_RST),
    .tick   (tick),
    .en     (cnt_en_reg),
    .clr    (cnt_clr),
    .modulo (modulo_reg),
    .count  (count),
    .match  (match)
  );

  // Generator runs while gated, holding, or clocking the timer
  assign car_run = gate_reg || hold_reg || cnt_sel_reg == TCK_CARR;

  ict_carrier_gen #(
    .W (CW)
  ) u_carrier (
    .clk         (I_CORE_CLK),
    .rst         (I_SYS_RST),
    .run         (car_run),
    .sel         (car_sel_reg),
    .high_period (high_reg),
    .low_period  (low_reg),
    .level       (car_level),
    .fall        (car_fall)
  );

  // Register-file writes and hardware updates
  always_comb begin
    gate_buf_next = gate_buf_reg;
    gate_next     = gate_reg;
    car_dis_next  = car_dis_reg;
    car_sel_next  = car_sel_reg;
    cnt_en_next   = cnt_en_reg;
    cnt_sel_next  = cnt_sel_reg;
    flag_next     = flag_reg;
    if (rf_wr) begin
      case (I_RF_REQ.addr)
        RF_GATE_BUF: gate_buf_next = I_RF_REQ.wdata[B_GATE_BUF];
        RF_GATE: begin
          gate_next    = I_RF_REQ.wdata[B_GATE];
          car_dis_next = I_RF_REQ.wdata[B_CAR_DIS];
        end
        RF_CAR_SEL:  car_sel_next = I_RF_REQ.wdata[1:0];
        RF_TMR_CTL: begin
          cnt_en_next  = I_RF_REQ.wdata[B_CNT_EN];
          cnt_sel_next = I_RF_REQ.wdata[1:0];
        end
        RF_IRQ:      flag_next = I_RF_REQ.wdata[B_IRQ];
        default:     flag_next = flag_reg;
      endcase
    end
    if (cnt_clr) begin
      flag_next = 1'b0;
    end
    if (match) begin
      flag_next = 1'b1;
      gate_next = gate_buf_reg;
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      gate_buf_reg <= GATE_RST;
      gate_reg     <= GATE_RST;
      car_dis_reg  <= CAR_DIS_RST;
      car_sel_reg  <= CAR_SEL_RST;
      cnt_en_reg   <= TMR_CTL_RST[B_CNT_EN];
      cnt_sel_reg  <= TMR_CTL_RST[1:0];
      flag_reg     <= 1'b0;
    end else begin
      gate_buf_reg <= gate_buf_next;
      gate_reg     <= gate_next;
      car_dis_reg  <= car_dis_next;
      car_sel_reg  <= car_sel_next;
      cnt_en_reg   <= cnt_en_next;
      cnt_sel_reg  <= cnt_sel_next;
      flag_reg     <= flag_next;
    end
  end

  // Peripheral register writes through the transfer buffer
  always_comb begin
    modulo_next = modulo_reg;
    high_next   = high_reg;
    low_next    = low_reg;
    if (I_PER_REQ.peripheral_write_instr) begin
      case (I_PER_REQ.addr)
        PR_TIMER:   modulo_next = I_PER_REQ.wdata[7:0];
        PR_CARRIER: begin
          high_next = I_PER_REQ.wdata[15:8];
          low_next  = I_PER_REQ.wdata[7:0];
        end
        default:    modulo_next = modulo_reg;
      endcase
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      modulo_reg <= PERIOD_RST;
      high_reg   <= PERIOD_RST;
      low_reg    <= PERIOD_RST;
    end else begin
      modulo_reg <= modulo_next;
      high_reg   <= high_next;
      low_reg    <= low_next;
    end
  end

  // Pin drive with full-width high pulses across match-driven gate changes
  always_comb begin
    hold_next = hold_reg;
    if (match && gate_reg && car_level) begin
      hold_next = 1'b1;
    end else if (!car_level) begin
      hold_next = 1'b0;
    end
    if (car_dis_reg) begin
      pin_next = 1'b1;
    end else begin
      pin_next = (gate_reg || hold_next) && car_level;
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      hold_reg <= 1'b0;
      pin_reg  <= 1'b0;
    end else begin
      hold_reg <= hold_next;
      pin_reg  <= pin_next;
    end
  end

  // Read paths; register file follows the address every cycle
  always_comb begin
    case (I_RF_REQ.addr)
      RF_GATE_BUF: rf_rd_next = {3'h0, gate_buf_reg};
      RF_GATE:     rf_rd_next = {2'h0, car_dis_reg, gate_reg};
      RF_CAR_SEL:  rf_rd_next = {2'h0, car_sel_reg};
      RF_TMR_CTL:  rf_rd_next = {cnt_en_reg, 1'b0, cnt_sel_reg};
      RF_IRQ:      rf_rd_next = {3'h0, flag_reg};
      default:     rf_rd_next = 4'h0;
    endcase
    per_rd_next = per_rd_reg;
    if (I_PER_REQ.peripheral_read_instr) begin
      case (I_PER_REQ.addr)
        PR_TIMER:   per_rd_next = {8'h00, count};
        PR_CARRIER: per_rd_next = {high_reg, low_reg};
        default:    per_rd_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      rf_rd_reg  <= 4'h0;
      per_rd_reg <= 16'h0000;
    end else begin
      rf_rd_reg  <= rf_rd_next;
      per_rd_reg <= per_rd_next;
    end
  end

  assign O_RF_RDATA        = rf_rd_reg;
  assign O_PER_RDATA       = per_rd_reg;
  assign O_MATCH_IRQ_FLAG  = flag_reg;
  assign O_CARRIER_OUT_PIN = pin_reg;

endmodule // ict_top

// ### shared/ict_pkg.sv
package ict_pkg;

  // Register-file locations (4-bit words)
  localparam logic [6:0] RF_GATE_BUF = 7'h11;
  localparam logic [6:0] RF_GATE     = 7'h12;
  localparam logic [6:0] RF_CAR_SEL  = 7'h13;
  localparam logic [6:0] RF_TMR_CTL  = 7'h33;
  localparam logic [6:0] RF_IRQ      = 7'h3F;

  // Bit positions inside those locations
  localparam int B_GATE_BUF  = 0;
  localparam int B_GATE      = 0;
  localparam int B_CAR_DIS   = 1;
  localparam int B_CNT_EN    = 3;
  localparam int B_CNT_CLR   = 2;
  localparam int B_IRQ       = 0;

  // Reset values
  localparam logic [3:0] TMR_CTL_RST = 4'h8;
  localparam logic [1:0] CAR_SEL_RST = 2'h0;
  localparam logic       GATE_RST    = 1'b0;
  localparam logic       CAR_DIS_RST = 1'b0;
  localparam logic [7:0] PERIOD_RST  = 8'h00;

  // Peripheral registers behind the transfer buffer
  localparam logic [2:0] PR_TIMER   = 3'h2;
  localparam logic [2:0] PR_CARRIER = 3'h3;

  // Count clock selections
  localparam logic [1:0] TCK_DIV32  = 2'b00;
  localparam logic [1:0] TCK_DIV64  = 2'b01;
  localparam logic [1:0] TCK_DIV256 = 2'b10;
  localparam logic [1:0] TCK_CARR   = 2'b11;
  localparam logic [7:0] DIV32_MASK  = 8'h1F;
  localparam logic [7:0] DIV64_MASK  = 8'h3F;
  localparam logic [7:0] DIV256_MASK = 8'hFF;

  // Carrier clock selections and their period in half system-clock units
  localparam logic [1:0] CCK_HALF   = 2'b00;
  localparam logic [1:0] CCK_FULL   = 2'b01;
  localparam logic [1:0] CCK_DOUBLE = 2'b10;
  localparam int         SH_HALF    = 2;
  localparam int         SH_FULL    = 1;
  localparam int         SH_DOUBLE  = 0;
  localparam int         UNITS_PER_CLK = 2;

  typedef struct packed {
    logic       we;
    logic [6:0] addr;
    logic [3:0] wdata;
  } ict_rf_req_t;

  typedef struct packed {
    logic        peripheral_write_instr;
    logic        peripheral_read_instr;
    logic [2:0]  addr;
    logic [15:0] wdata;
  } ict_per_req_t;

  typedef enum logic {PH_LOW = 1'b0, PH_HIGH = 1'b1} ict_phase_t;

endpackage

// ### sim/ict_led_model.sv
`timescale 1ns/1ps
module ict_led_model (
  input  wire logic i_clk,
  input  wire logic i_pin,
  output int        o_hi_w,
  output int        o_lo_w
);
  int   run  = 0;
  logic last = 1'b0;
  // Passive load: widths of the last full high and low phase
  always @(posedge i_clk) begin
    if (i_pin !== last) begin
      if (last) o_hi_w <= run;
      else o_lo_w <= run;
      run <= 1;
    end else begin
      run <= run + 1;
    end
    last <= i_pin;
  end
endmodule // ict_led_model

// ### sim/ict_top_sva.sv
`timescale 1ns/1ps
module ict_top_sva (
  input wire logic                  I_CORE_CLK,
  input wire logic                  I_SYS_RST,
  input wire ict_pkg::ict_rf_req_t  I_RF_REQ,
  input wire ict_pkg::ict_per_req_t I_PER_REQ,
  input wire logic [3:0]            O_RF_RDATA,
  input wire logic [15:0]           O_PER_RDATA,
  input wire logic                  O_MATCH_IRQ_FLAG,
  input wire logic                  O_CARRIER_OUT_PIN
);
  import ict_pkg::*;
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_SYS_RST);
  // Access steps
  sequence s_clr;
    I_RF_REQ.we && I_RF_REQ.addr == RF_TMR_CTL && I_RF_REQ.wdata[B_CNT_CLR];
  endsequence
  sequence s_dis;
    I_RF_REQ.we && I_RF_REQ.addr == RF_GATE && I_RF_REQ.wdata[B_CAR_DIS];
  endsequence
  sequence s_cput;
    I_PER_REQ.peripheral_write_instr && I_PER_REQ.addr == PR_CARRIER;
  endsequence
  sequence s_cget;
    I_PER_REQ.peripheral_read_instr && !I_PER_REQ.peripheral_write_instr && I_PER_REQ.addr == PR_CARRIER;
  endsequence
  // Register and pin relations
  property p_clr_flag; s_clr |=> !O_MATCH_IRQ_FLAG; endproperty
  property p_clr_rd; I_RF_REQ.addr == RF_TMR_CTL |=> !O_RF_RDATA[B_CNT_CLR]; endproperty
  property p_irq_rd; I_RF_REQ.addr == RF_IRQ |=> O_RF_RDATA[3:1] == 3'h0; endproperty
  property p_sel_rd; I_RF_REQ.addr == RF_CAR_SEL |=> O_RF_RDATA[3:2] == 2'h0; endproperty
  property p_per_none;
    I_PER_REQ.peripheral_read_instr && I_PER_REQ.addr != PR_TIMER && I_PER_REQ.addr != PR_CARRIER
      |=> O_PER_RDATA == 16'h0000;
  endproperty
  property p_cnt_hi; I_PER_REQ.peripheral_read_instr && I_PER_REQ.addr == PR_TIMER |=> O_PER_RDATA[15:8] == 8'h00;
  endproperty
  property p_car_rb; s_cput ##1 s_cget |=> O_PER_RDATA == $past(I_PER_REQ.wdata, 2); endproperty
  property p_hold; !I_PER_REQ.peripheral_read_instr |=> $stable(O_PER_RDATA); endproperty
  property p_dis;
    s_dis ##1 !(I_RF_REQ.we && I_RF_REQ.addr == RF_GATE) |-> ##[0:1] O_CARRIER_OUT_PIN;
  endproperty
  property p_rst_low; $fell(I_SYS_RST) |-> !O_CARRIER_OUT_PIN [*4]; endproperty
  a_clr_flag: assert property (p_clr_flag) else $error("flag kept after clear");
  a_clr_rd: assert property (p_clr_rd) else $error("clear bit read as one");
  a_irq_rd: assert property (p_irq_rd) else $error("flag word upper bits set");
  a_sel_rd: assert property (p_sel_rd) else $error("select word upper bits set");
  a_per_none: assert property (p_per_none) else $error("unmapped read not zero");
  a_cnt_hi: assert property (p_cnt_hi) else $error("count upper byte set");
  a_car_rb: assert property (p_car_rb) else $error("period readback wrong");
  a_hold: assert property (p_hold) else $error("read data moved");
  a_dis: assert property (p_dis) else $error("pin not forced high");
  a_rst_low: assert property (p_rst_low) else $error("pin high with gate off");
endmodule // ict_top_sva

bind ict_top ict_top_sva u_sva (
  .I_CORE_CLK(I_CORE_CLK), .I_SYS_RST(I_SYS_RST), .I_RF_REQ(I_RF_REQ),
  .I_PER_REQ(I_PER_REQ), .O_RF_RDATA(O_RF_RDATA), .O_PER_RDATA(O_PER_RDATA),
  .O_MATCH_IRQ_FLAG(O_MATCH_IRQ_FLAG), .O_CARRIER_OUT_PIN(O_CARRIER_OUT_PIN));

// ### sim/ict_top_tb.sv
`timescale 1ns/1ps
module ict_top_tb;
  import ict_pkg::*;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  ict_rf_req_t  rq  = '0;
  ict_per_req_t pq  = '0;
  logic [3:0]   rd;
  logic [15:0]  pd, v;
  logic         fl, pin;
  logic [31:0]  rs  = 32'h0001_0FD8;
  int           mismatches = 0, compares = 0, cyc = 0;
  int           hw, lw, t0, t1, m, h, l;

  ict_top dut (.I_CORE_CLK(clk), .I_SYS_RST(rst), .I_RF_REQ(rq), .I_PER_REQ(pq),
    .O_RF_RDATA(rd), .O_PER_RDATA(pd), .O_MATCH_IRQ_FLAG(fl), .O_CARRIER_OUT_PIN(pin));
  ict_led_model led (.i_clk(clk), .i_pin(pin), .o_hi_w(hw), .o_lo_w(lw));

  // Clock and hang guard
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      conclude();
    end
  end

  function automatic logic [31:0] lf(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Phase length in cycles for a carrier clock select
  function automatic int ph(int c, int n);
    return c == 0 ? 2 * (n + 1) : c == 1 ? n + 1 : (n + 1) / 2;
  endfunction
  function automatic int per(int s, int mo, int cy);
    return (mo + 1) * (s == 0 ? 32 : s == 1 ? 64 : s == 2 ? 256 : cy);
  endfunction

  task automatic conclude();
    if (mismatches == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // Bus cycles, each entered and left at a falling edge
  task automatic rfw(logic [6:0] a, logic [3:0] d);
    rq = '{1'b1, a, d};
    @(negedge clk);
    rq.we = 1'b0;
    @(negedge clk);
  endtask
  // Stop counting first, then clear, so no late match meets the clear
  task automatic halt();
    rfw(RF_TMR_CTL, 4'h0);
    rfw(RF_TMR_CTL, 4'h4);
  endtask
  task automatic rfr(logic [6:0] a, logic [3:0] e, string n);
    rq.addr = a;
    @(negedge clk);
    chk(n, {12'h000, e}, {12'h000, rd});
  endtask
  task automatic pput(logic [2:0] a, logic [15:0] d);
    pq.peripheral_write_instr = 1'b1;
    pq.addr = a;
    pq.wdata = d;
    @(negedge clk);
    pq.peripheral_write_instr = 1'b0;
  endtask
  task automatic pget(logic [2:0] a, output logic [15:0] r);
    pq.peripheral_read_instr = 1'b1;
    pq.addr = a;
    @(negedge clk);
    pq.peripheral_read_instr = 1'b0;
    r = pd;
    @(negedge clk);
  endtask
  // Wait for the match flag, note the time, clear the flag
  task automatic wfl(output int t);
    int k;
    k = 0;
    while (fl !== 1'b1 && k < 3000) begin
      @(negedge clk);
      k++;
    end
    t = cyc;
    if (k >= 3000) mismatches++;
    rfw(RF_IRQ, 4'h0);
  endtask

  // Main sequence
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    rfr(RF_TMR_CTL, TMR_CTL_RST, "timer ctl");
    rfr(RF_CAR_SEL, 4'h0, "carrier sel");
    rfr(RF_GATE, 4'h0, "gate");
    rfr(RF_IRQ, 4'h0, "flag");
    rfr(7'h40, 4'h0, "unmapped rf");
    pget(3'h5, v);
    chk("unmapped per", 16'h0000, v);
    for (int i = 0; i < 4; i++) begin
      rs = lf(rs);
      pput(PR_CARRIER, rs[15:0]);
      pget(PR_CARRIER, v);
      chk("periods", rs[15:0], v);
    end
    pput(PR_TIMER, 16'h00FF);
    rfw(RF_TMR_CTL, 4'hC);
    rfr(RF_TMR_CTL, 4'h8, "clear reads");
    pget(PR_TIMER, v);
    chk("count", 16'h0000, v & 16'hFFFE);
    for (int i = 0; i < 3; i++) begin
      rs = lf(rs);
      m = 1 + int'(rs[1:0]);
      pput(PR_TIMER, {8'h00, 8'(m)});
      halt();
      rfw(RF_TMR_CTL, {2'b11, 2'(i)});
      wfl(t0);
      wfl(t1);
      chk("interval", 16'(per(i, m, 0)), 16'(t1 - t0));
    end
    halt();
    repeat (300) @(negedge clk);
    chk("stopped flag", 16'h0000, {15'h0000, fl});
    for (int c = 0; c < 3; c++) begin
      halt();
      rs = lf(rs);
      h = int'(rs[3:0]) | 1;
      l = int'(rs[7:4]) | 1;
      pput(PR_CARRIER, {8'(h), 8'(l)});
      rfw(RF_CAR_SEL, 4'(c));
      rfw(RF_GATE_BUF, 4'h1);
      rfw(RF_TMR_CTL, 4'hC);
      wfl(t0);
      repeat (300) @(negedge clk);
      chk("high", 16'(ph(c, h)), 16'(hw));
      chk("low", 16'(ph(c, l)), 16'(lw));
      rfw(RF_GATE_BUF, 4'h0);
      wfl(t0);
      wfl(t0);
      repeat (100) @(negedge clk);
      chk("last high", 16'(ph(c, h)), 16'(hw));
      chk("pin off", 16'h0000, {15'h0000, pin});
    end
    pput(PR_CARRIER, 16'h0102);
    rfw(RF_CAR_SEL, 4'h0);
    pput(PR_TIMER, 16'h0002);
    halt();
    rfw(RF_TMR_CTL, 4'hF);
    wfl(t0);
    wfl(t1);
    chk("carrier tick", 16'(per(3, 2, ph(0, 1) + ph(0, 2))), 16'(t1 - t0));
    chk("pin idle", 16'h0000, {15'h0000, pin});
    rfw(RF_GATE, 4'h2);
    repeat (2) @(negedge clk);
    for (int i = 0; i < 20; i++) begin
      chk("forced", 16'h0001, {15'h0000, pin});
      @(negedge clk);
    end
    conclude();
  end
endmodule // ict_top_tb
